// [verilog/cpr_pkg.sv]
// Constants and types shared by the coprocessor dialog host controller
package cpr_pkg;
   // ==========================================================
   // Device interface register locations
   // ==========================================================
   localparam int CIR_AW = 5;
   localparam logic [4:0] CIR_RESP = 5'h00;
   localparam logic [4:0] CIR_CTRL = 5'h02;
   localparam logic [4:0] CIR_SAVE = 5'h04;
   localparam logic [4:0] CIR_RESTORE = 5'h06;
   localparam logic [4:0] CIR_CMD = 5'h0a;
   localparam logic [4:0] CIR_COND = 5'h0e;
   localparam logic [15:0] ABORT_VAL = 16'h0001;
   // ==========================================================
   // Operation word and primitive fields
   // ==========================================================
   localparam logic [3:0] FLINE = 4'hf;
   localparam logic [2:0] DEV_SEL = 3'h0;
   localparam int SEL_HI = 11;
   localparam int SEL_LO = 9;
   localparam int TYPE_HI = 8;
   localparam int TYPE_LO = 6;
   localparam int BIT_CA = 15;
   localparam int BIT_PC = 14;
   localparam int BIT_DR = 13;
   localparam int BIT_IA = 8;
   localparam int BIT_PF = 1;
   localparam int BIT_TF = 0;
   localparam logic [4:0] NULL_FIXED = 5'h04;
   localparam logic [15:0] SUPV_PRIM = 16'h8400;
   // ==========================================================
   // Software register map and fields
   // ==========================================================
   localparam logic [4:0] SW_CTRL = 5'h00;
   localparam logic [4:0] SW_STAT = 5'h04;
   localparam logic [4:0] SW_INSN = 5'h08;
   localparam logic [4:0] SW_RESP = 5'h0c;
   localparam logic [4:0] SW_DATA = 5'h10;
   localparam int CTL_START = 0;
   localparam int CTL_CONT = 1;
   localparam int CTL_ABORT = 2;
   localparam int CTL_SUPV = 3;
   localparam logic CTL_SUPV_RST = 1'b0;
   localparam int MAX_WORDS_DEF = 8;
   localparam int MAX_REREAD_DEF = 64;
   typedef enum logic [2:0] {
      K_GEN, K_COND, K_BRANCH, K_SAVE, K_RESTORE, K_ILLEGAL
   } cpr_kind_e;
endpackage

// [verilog/cpr_insn_mem.sv]
// Small instruction word store with registered read port
`timescale 1ns/1ps
module cpr_insn_mem #(
   parameter int unsigned DEPTH = 8,
   parameter int unsigned WIDTH = 16
) (
   input wire logic ref_clk_in,
   input wire logic wr_en_in,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] rd_d;

   if (DEPTH < 2) begin : g_chk
      $error("cpr_insn_mem: depth below two");
   end

   always_comb begin
      rd_d = mem_q[rd_addr_in];
   end

   // No reset on the array: word 0 is written before any start, but a one-word instruction still reads word 1, which may be stale
   always_ff @(posedge ref_clk_in) begin
      if (wr_en_in) begin
         mem_q[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= rd_d;
   end
endmodule // cpr_insn_mem

// [verilog/cpr_prim_decode.sv]
// Registered classifier for primitives read from the response location
`timescale 1ns/1ps
module cpr_prim_decode (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic valid_in,
   input wire logic [15:0] prim_in,
   output logic [15:0] prim_out,
   output logic is_null_out,
   output logic is_supv_out
);
   logic [15:0] prim_d;
   logic null_d;
   logic supv_d;

   always_comb begin
      prim_d = prim_out;
      null_d = is_null_out;
      supv_d = is_supv_out;
      if (valid_in) begin
         prim_d = prim_in;
         // Null: fixed field 13..9, zero in 7..2
         null_d = prim_in[cpr_pkg::BIT_DR:9] == cpr_pkg::NULL_FIXED
            && prim_in[7:2] == 6'h00;
         supv_d = prim_in == cpr_pkg::SUPV_PRIM;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         prim_out <= 16'h0000;
         is_null_out <= 1'b0;
         is_supv_out <= 1'b0;
      end else begin
         prim_out <= prim_d;
         is_null_out <= null_d;
         is_supv_out <= supv_d;
      end
   end
endmodule // cpr_prim_decode

// [verilog/cpr_host_ctrl.sv]
// Host-side controller that runs coprocessor dialogs with the device
// Contract
// - Host starts every transfer, writes and reads
// - Instruction is one to eight words
// - Top nibble all ones means coprocessor instruction
// - Selector zero addresses the device only
// - Type field picks one of five dialogs
// - Open by write; save opens by read
// - Then read response: exception, service, reread, check
// - Come-again set: serve, then read again
// - Bit 13 gives transfer direction
// - Bit 0 is condition result, else ignored
// - Busy null: come-again set, read again
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
module cpr_host_ctrl #(
   parameter int unsigned MAX_WORDS = cpr_pkg::MAX_WORDS_DEF,
   parameter int unsigned MAX_REREAD = cpr_pkg::MAX_REREAD_DEF
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [4:0] sw_addr_in,
   input wire logic [31:0] sw_wdata_in,
   input wire logic sw_wr_in,
   input wire logic sw_rd_in,
   output logic [31:0] sw_rdata_out,
   output logic [2:0] cir_sel_out,
   output logic [4:0] cir_addr_out,
   output logic [15:0] cir_wdata_out,
   output logic cir_wr_out,
   output logic cir_rd_out,
   input wire logic [15:0] cir_rdata_in
);
   // ==========================================================
   // Parameter checks and types
   // ==========================================================
   if (MAX_WORDS < 2 || MAX_WORDS > 8) begin : g_chk_w
      $error("cpr_host_ctrl: MAX_WORDS must be 2..8");
   end
   if (MAX_REREAD < 2 || MAX_REREAD > 65535) begin : g_chk_r
      $error("cpr_host_ctrl: MAX_REREAD must be 2..65535");
   end

   typedef enum logic [3:0] {
      S_IDLE, S_FETCH_OP, S_FETCH_CMD, S_CHECK, S_OPENED,
      S_SAVE_DATA, S_RESP_STB, S_RESP_DATA, S_DECODE,
      S_SERVICE, S_ABORT
   } cpr_state_e;

   function automatic cpr_pkg::cpr_kind_e kind_of(input logic [15:0] w);
      case (w[cpr_pkg::TYPE_HI:cpr_pkg::TYPE_LO])
         3'h0: kind_of = cpr_pkg::K_GEN;
         3'h1: kind_of = cpr_pkg::K_COND;
         3'h2, 3'h3: kind_of = cpr_pkg::K_BRANCH;
         3'h4: kind_of = cpr_pkg::K_SAVE;
         3'h5: kind_of = cpr_pkg::K_RESTORE;
         default: kind_of = cpr_pkg::K_ILLEGAL;
      endcase
   endfunction

   // ==========================================================
   // State
   // ==========================================================
   cpr_state_e state_q, state_d;
   cpr_pkg::cpr_kind_e kind_q, kind_d;
   logic [15:0] op_q, op_d, cmd_q, cmd_d, data_q, data_d;
   logic [15:0] save_q, save_d;
   logic [3:0] cnt_q, cnt_d;
   logic [15:0] rr_q, rr_d;
   logic supv_q, supv_d, done_q, done_d, tf_q, tf_d, svc_q, svc_d;
   logic efmt_q, efmt_d, epriv_q, epriv_d, eto_q, eto_d;
   logic epc_q, epc_d;
   logic [2:0] sel_d;
   logic [4:0] addr_d;
   logic [15:0] wdata_d;
   logic wr_d, rd_d;
   logic [31:0] rdata_d;
   logic [15:0] mem_rd;
   logic [15:0] prim;
   logic p_null, p_supv, busy;
   logic ins_wr, sw_start, sw_cont, sw_abort;

   assign busy = state_q != S_IDLE;
   assign ins_wr = sw_wr_in && sw_addr_in == cpr_pkg::SW_INSN && !busy
      && cnt_q < 4'(MAX_WORDS);
   assign sw_start = sw_wr_in && sw_addr_in == cpr_pkg::SW_CTRL
      && sw_wdata_in[cpr_pkg::CTL_START];
   assign sw_cont = sw_wr_in && sw_addr_in == cpr_pkg::SW_CTRL
      && sw_wdata_in[cpr_pkg::CTL_CONT];
   assign sw_abort = sw_wr_in && sw_addr_in == cpr_pkg::SW_CTRL
      && sw_wdata_in[cpr_pkg::CTL_ABORT];

   cpr_insn_mem #(.DEPTH(8), .WIDTH(16)) u_mem (
      .ref_clk_in(ref_clk_in),
      .wr_en_in(ins_wr),
      .wr_addr_in(cnt_q[2:0]),
      .wr_data_in(sw_wdata_in[15:0]),
      .rd_addr_in(state_q == S_FETCH_OP ? 3'h0 : 3'h1),
      .rd_data_out(mem_rd)
   );

   cpr_prim_decode u_dec (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .valid_in(state_q == S_RESP_DATA),
      .prim_in(cir_rdata_in),
      .prim_out(prim),
      .is_null_out(p_null),
      .is_supv_out(p_supv)
   );

   // ==========================================================
   // Dialog sequencer
   // ==========================================================
   always_comb begin
      state_d = state_q;
      kind_d = kind_q;
      op_d = op_q;
      cmd_d = cmd_q;
      data_d = data_q;
      save_d = save_q;
      cnt_d = cnt_q;
      rr_d = rr_q;
      supv_d = supv_q;
      done_d = done_q;
      tf_d = tf_q;
      svc_d = svc_q;
      efmt_d = efmt_q;
      epriv_d = epriv_q;
      eto_d = eto_q;
      epc_d = epc_q;
      sel_d = cir_sel_out;
      addr_d = cir_addr_out;
      wdata_d = cir_wdata_out;
      wr_d = 1'b0;
      rd_d = 1'b0;
      if (ins_wr) begin
         cnt_d = cnt_q + 4'h1;
      end
      if (sw_wr_in && sw_addr_in == cpr_pkg::SW_DATA && !busy) begin
         data_d = sw_wdata_in[15:0];
      end
      if (sw_wr_in && sw_addr_in == cpr_pkg::SW_CTRL) begin
         supv_d = sw_wdata_in[cpr_pkg::CTL_SUPV];
      end
      unique case (state_q)
         S_IDLE: begin
            if (sw_start && cnt_q != 4'h0) begin
               done_d = 1'b0;
               svc_d = 1'b0;
               efmt_d = 1'b0;
               epriv_d = 1'b0;
               eto_d = 1'b0;
               epc_d = 1'b0;
               state_d = S_FETCH_OP;
            end
         end
         S_FETCH_OP: state_d = S_FETCH_CMD;
         S_FETCH_CMD: begin
            op_d = mem_rd;
            kind_d = kind_of(mem_rd);
            state_d = S_CHECK;
         end
         S_CHECK: begin
            cmd_d = mem_rd;
            cnt_d = 4'h0;
            rr_d = 16'h0000;
            sel_d = op_q[cpr_pkg::SEL_HI:cpr_pkg::SEL_LO];
            // Anything not aimed at the device raises no strobe, though its selector still reaches cir_sel_out
            if (op_q[15:12] != cpr_pkg::FLINE
                || op_q[cpr_pkg::SEL_HI:cpr_pkg::SEL_LO]
                   != cpr_pkg::DEV_SEL
                || kind_q == cpr_pkg::K_ILLEGAL
                || (kind_q == cpr_pkg::K_GEN && cnt_q < 4'h2)) begin
               efmt_d = 1'b1;
               state_d = S_IDLE;
            end else begin
               state_d = S_OPENED;
               unique case (kind_q)
                  cpr_pkg::K_GEN: begin
                     addr_d = cpr_pkg::CIR_CMD;
                     wdata_d = mem_rd;
                     wr_d = 1'b1;
                  end
                  cpr_pkg::K_COND: begin
                     addr_d = cpr_pkg::CIR_COND;
                     wdata_d = {10'h000, mem_rd[5:0]};
                     wr_d = 1'b1;
                  end
                  cpr_pkg::K_BRANCH: begin
                     addr_d = cpr_pkg::CIR_COND;
                     wdata_d = {10'h000, op_q[5:0]};
                     wr_d = 1'b1;
                  end
                  cpr_pkg::K_RESTORE: begin
                     addr_d = cpr_pkg::CIR_RESTORE;
                     wdata_d = data_q;
                     wr_d = 1'b1;
                  end
                  cpr_pkg::K_SAVE: begin
                     addr_d = cpr_pkg::CIR_SAVE;
                     rd_d = 1'b1;
                  end
                  default: state_d = S_IDLE;
               endcase
            end
         end
         S_OPENED: begin
            if (kind_q == cpr_pkg::K_SAVE) begin
               state_d = S_SAVE_DATA;
            end else begin
               addr_d = cpr_pkg::CIR_RESP;
               rd_d = 1'b1;
               state_d = S_RESP_STB;
            end
         end
         S_SAVE_DATA: begin
            save_d = cir_rdata_in;
            done_d = 1'b1;
            state_d = S_IDLE;
         end
         S_RESP_STB: state_d = S_RESP_DATA;
         S_RESP_DATA: state_d = S_DECODE;
         S_DECODE: begin
            addr_d = cpr_pkg::CIR_RESP;
            if (prim[cpr_pkg::BIT_PC]) begin
               epc_d = 1'b1;
               state_d = S_ABORT;
            end else if (p_null && !prim[cpr_pkg::BIT_CA]
                         && prim[cpr_pkg::BIT_PF]) begin
               done_d = 1'b1;
               if (kind_q == cpr_pkg::K_COND
                   || kind_q == cpr_pkg::K_BRANCH) begin
                  tf_d = prim[cpr_pkg::BIT_TF];
               end
               state_d = S_IDLE;
            end else if (p_null || (p_supv && supv_q)) begin
               // Bounded so a stuck device cannot hang the host forever
               if (rr_q == 16'(MAX_REREAD - 1)) begin
                  eto_d = 1'b1;
                  state_d = S_ABORT;
               end else begin
                  rr_d = rr_q + 16'h0001;
                  rd_d = 1'b1;
                  state_d = S_RESP_STB;
               end
            end else if (p_supv) begin
               epriv_d = 1'b1;
               state_d = S_ABORT;
            end else begin
               svc_d = 1'b1;
               state_d = S_SERVICE;
            end
         end
         S_SERVICE: begin
            if (sw_abort) begin
               svc_d = 1'b0;
               state_d = S_ABORT;
            end else if (sw_cont) begin
               svc_d = 1'b0;
               rr_d = 16'h0000;
               if (prim[cpr_pkg::BIT_CA]) begin
                  addr_d = cpr_pkg::CIR_RESP;
                  rd_d = 1'b1;
                  state_d = S_RESP_STB;
               end else begin
                  done_d = 1'b1;
                  state_d = S_IDLE;
               end
            end
         end
         S_ABORT: begin
            addr_d = cpr_pkg::CIR_CTRL;
            wdata_d = cpr_pkg::ABORT_VAL;
            wr_d = 1'b1;
            state_d = S_IDLE;
         end
      endcase
   end

   // Read data stand only in the cycle after the read strobe
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (sw_rd_in) begin
         unique case (sw_addr_in)
            cpr_pkg::SW_CTRL: rdata_d = {28'h0, supv_q, 3'h0};
            cpr_pkg::SW_STAT: rdata_d = {20'h0, cnt_q, epc_q, eto_q,
               epriv_q, efmt_q, svc_q, tf_q, done_q, busy};
            cpr_pkg::SW_INSN: rdata_d = {28'h0, cnt_q};
            cpr_pkg::SW_RESP: rdata_d = {16'h0, prim};
            cpr_pkg::SW_DATA: rdata_d = {save_q, data_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rstn_in) begin
         state_q <= S_IDLE;
         kind_q <= cpr_pkg::K_GEN;
         op_q <= 16'h0000;
         cmd_q <= 16'h0000;
         data_q <= 16'h0000;
         save_q <= 16'h0000;
         cnt_q <= 4'h0;
         rr_q <= 16'h0000;
         supv_q <= cpr_pkg::CTL_SUPV_RST;
         {done_q, tf_q, svc_q} <= 3'h0;
         {efmt_q, epriv_q, eto_q, epc_q} <= 4'h0;
         cir_sel_out <= cpr_pkg::DEV_SEL;
         cir_addr_out <= cpr_pkg::CIR_RESP;
         cir_wdata_out <= 16'h0000;
         cir_wr_out <= 1'b0;
         cir_rd_out <= 1'b0;
         sw_rdata_out <= 32'h0000_0000;
      end else begin
         state_q <= state_d;
         kind_q <= kind_d;
         op_q <= op_d;
         cmd_q <= cmd_d;
         data_q <= data_d;
         save_q <= save_d;
         cnt_q <= cnt_d;
         rr_q <= rr_d;
         supv_q <= supv_d;
         {done_q, tf_q, svc_q} <= {done_d, tf_d, svc_d};
         {efmt_q, epriv_q, eto_q, epc_q} <= {efmt_d, epriv_d, eto_d, epc_d};
         cir_sel_out <= sel_d;
         cir_addr_out <= addr_d;
         cir_wdata_out <= wdata_d;
         cir_wr_out <= wr_d;
         cir_rd_out <= rd_d;
         sw_rdata_out <= rdata_d;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);

   property p_one_strobe;
      !(cir_wr_out && cir_rd_out);
   endproperty
   a_one_strobe: assert property (p_one_strobe)
      else $error("read and write strobes together");

   property p_word_cap;
      cnt_q <= 4'(MAX_WORDS);
   endproperty
   a_word_cap: assert property (p_word_cap)
      else $error("instruction longer than allowed");

   property p_fline;
      (cir_wr_out && cir_addr_out != cpr_pkg::CIR_CTRL)
         |-> op_q[15:12] == cpr_pkg::FLINE;
   endproperty
   a_fline: assert property (p_fline)
      else $error("dialog opened for a non coprocessor word");

   property p_sel_zero;
      (cir_wr_out || cir_rd_out) |-> cir_sel_out == cpr_pkg::DEV_SEL;
   endproperty
   a_sel_zero: assert property (p_sel_zero)
      else $error("access to a foreign selector");

   property p_open_cmd;
      (cir_wr_out && cir_addr_out == cpr_pkg::CIR_CMD)
         |-> kind_q == cpr_pkg::K_GEN && cir_wdata_out == cmd_q;
   endproperty
   a_open_cmd: assert property (p_open_cmd)
      else $error("command location written for wrong type");

   property p_save_rd;
      (cir_rd_out && cir_addr_out == cpr_pkg::CIR_SAVE)
         |-> kind_q == cpr_pkg::K_SAVE ##2 done_q && !busy;
   endproperty
   a_save_rd: assert property (p_save_rd)
      else $error("save read not completed in time");

   property p_resp_after_open;
      (cir_wr_out && cir_addr_out != cpr_pkg::CIR_CTRL)
         |=> cir_rd_out && cir_addr_out == cpr_pkg::CIR_RESP;
   endproperty
   a_resp_after_open: assert property (p_resp_after_open)
      else $error("no response read after opening write");

   property p_reread;
      (state_q == S_DECODE && p_null && !prim[cpr_pkg::BIT_PF]
         && !prim[cpr_pkg::BIT_PC] && rr_q < 16'(MAX_REREAD - 1))
         |=> cir_rd_out && cir_addr_out == cpr_pkg::CIR_RESP;
   endproperty
   a_reread: assert property (p_reread)
      else $error("busy null not followed by a reread");

   property p_come_again;
      (state_q == S_SERVICE && sw_cont && !sw_abort
         && prim[cpr_pkg::BIT_CA]) |=> cir_rd_out ##2 state_q == S_DECODE;
   endproperty
   a_come_again: assert property (p_come_again)
      else $error("come-again not followed by a response read");

   property p_tf_kind;
      $changed(tf_q) |-> $past(kind_q) inside
         {cpr_pkg::K_COND, cpr_pkg::K_BRANCH};
   endproperty
   a_tf_kind: assert property (p_tf_kind)
      else $error("condition result taken for wrong type");

   c_general: cover property (state_q == S_OPENED
      && kind_q == cpr_pkg::K_GEN ##[4:40] done_q && !busy);
   c_cond: cover property ($rose(tf_q));
   c_service: cover property (state_q == S_SERVICE ##[1:20] cir_rd_out);
   c_abort: cover property (state_q == S_ABORT);
endmodule // cpr_host_ctrl

// [verification/cpr_dev_model.sv]
// Behavioural device answering the controller on the coprocessor link
`timescale 1ns/1ps
module cpr_dev_model (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] sel_in,
   input wire logic [4:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [7:0] busy_reads_in,
   output logic [15:0] rdata_out
);
   localparam logic [15:0] SAVE_WORD = 16'h1f00;
   localparam logic [15:0] NULL_IDLE = 16'h0802;
   localparam logic [15:0] NULL_BUSY = 16'h8800;
   // Register-transfer request with come-again, answered once per SVC_CMD command
   localparam logic [15:0] SVC_PRIM = 16'h8c00;
   localparam logic [15:0] SVC_CMD = 16'h5a5a;
   logic svc_once = 1'b0;
   int busy_left = 0;
   int cond_step = 0;
   logic tf = 1'b0;
   int rsp_reads = 0;
   int strobes = 0;
   int sel_err = 0;
   int aborts = 0;
   // =====
   // Link responder
   // Answers only when asked; a released read bus flips every cycle
   always @(posedge ref_clk_in) begin
      rdata_out <= ~rdata_out;
      if (!rstn_in) begin
         busy_left = 0;
         cond_step = 0;
         rdata_out <= 16'h0000;
      end else if ((wr_in || rd_in) && sel_in != cpr_pkg::DEV_SEL) begin
         sel_err++;
      end else if (wr_in) begin
         strobes++;
         if (addr_in == cpr_pkg::CIR_CMD) begin
            // A command while busy drops both commands
            busy_left = (busy_left != 0) ? 0 : int'(busy_reads_in);
            svc_once = (wdata_in == SVC_CMD);
         end
         if (addr_in == cpr_pkg::CIR_COND) begin
            cond_step = 1;
            tf = wdata_in[0];
         end
         if (addr_in == cpr_pkg::CIR_CTRL) begin
            aborts++;
            busy_left = 0;
            cond_step = 0;
         end
      end else if (rd_in) begin
         strobes++;
         if (addr_in == cpr_pkg::CIR_SAVE) begin
            rdata_out <= SAVE_WORD;
         end
         if (addr_in == cpr_pkg::CIR_RESP) begin
            rsp_reads++;
            if (cond_step == 1) begin
               rdata_out <= cpr_pkg::SUPV_PRIM;
               cond_step = 2;
            end else if (cond_step == 2) begin
               rdata_out <= NULL_IDLE | {15'h0000, tf};
               cond_step = 0;
            end else if (svc_once) begin
               rdata_out <= SVC_PRIM;
               svc_once = 1'b0;
            end else if (busy_left != 0) begin
               rdata_out <= NULL_BUSY;
               busy_left--;
            end else begin
               rdata_out <= NULL_IDLE;
            end
         end
      end
   end
endmodule // cpr_dev_model

// [verification/cpr_host_ctrl_tb.sv]
// Self-checking bench for the coprocessor dialog host controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
   fails++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module cpr_host_ctrl_tb;
   logic clk, rstn, wr, rd, c_wr, c_rd;
   logic [4:0] addr, c_addr;
   logic [31:0] wdata, rdata, st, d;
   logic [2:0] c_sel;
   logic [15:0] c_wdata, c_rdata;
   logic [7:0] busy_reads;
   int fails = 0;
   int check_count = 0;
   int n0;
   cpr_host_ctrl #(.MAX_WORDS(8), .MAX_REREAD(4)) DUT (.ref_clk_in(clk),
      .rstn_in(rstn), .sw_addr_in(addr), .sw_wdata_in(wdata),
      .sw_wr_in(wr), .sw_rd_in(rd), .sw_rdata_out(rdata),
      .cir_sel_out(c_sel), .cir_addr_out(c_addr), .cir_wdata_out(c_wdata),
      .cir_wr_out(c_wr), .cir_rd_out(c_rd), .cir_rdata_in(c_rdata));
   cpr_dev_model u_dev (.ref_clk_in(clk), .rstn_in(rstn), .sel_in(c_sel),
      .addr_in(c_addr), .wdata_in(c_wdata), .wr_in(c_wr), .rd_in(c_rd),
      .busy_reads_in(busy_reads), .rdata_out(c_rdata));
   // =====
   // Bus tasks
   task automatic sw_wr(input logic [4:0] a, input logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic sw_rd(input logic [4:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Loads, starts, then polls until idle with an outcome flag set
   task automatic run(input logic [15:0] op, input logic [15:0] w1,
                      input int nw, input logic supv);
      sw_wr(cpr_pkg::SW_INSN, {16'h0000, op});
      if (nw > 1) sw_wr(cpr_pkg::SW_INSN, {16'h0000, w1});
      sw_wr(cpr_pkg::SW_CTRL, {28'h0000000, supv, 3'b001});
      st = '0;
      for (int i = 0; i < 80 && (st[0] || st[7:1] == 7'h00); i++) begin
         sw_rd(cpr_pkg::SW_STAT, st);
      end
   endtask
   // =====
   // Scenarios
   task automatic t_general();
      busy_reads = 8'h02;
      n0 = u_dev.rsp_reads;
      run(16'hf000, 16'h0123, 2, 1'b0);
      `CHK("done", 2'b10, st[1:0])
      `CHK("errors", 4'h0, st[7:4])
      `CHK("reads", 3, u_dev.rsp_reads - n0)
      sw_rd(cpr_pkg::SW_RESP, d);
      `CHK("resp", 16'h0802, d[15:0])
      `CHK("sel", 0, u_dev.sel_err)
   endtask
   task automatic t_cond(input logic supv, input logic pred);
      n0 = u_dev.aborts;
      run(16'hf040, {15'h0000, pred}, 2, supv);
      if (supv) begin
         `CHK("tf", pred, st[2])
         sw_rd(cpr_pkg::SW_RESP, d);
         `CHK("cresp", {15'h0401, pred}, d[15:0])
      end else begin
         `CHK("priv", 1'b1, st[5])
         `CHK("abort", 1, u_dev.aborts - n0)
      end
   endtask
   task automatic t_save();
      run(16'hf100, 16'h0000, 1, 1'b0);
      sw_rd(cpr_pkg::SW_DATA, d);
      `CHK("save", 16'h1f00, d[31:16])
      `CHK("sdone", 1'b1, st[1])
   endtask
   task automatic t_timeout();
      busy_reads = 8'h09;
      n0 = u_dev.aborts;
      run(16'hf000, 16'h0001, 2, 1'b0);
      `CHK("tmo", 1'b1, st[6])
      `CHK("tabort", 1, u_dev.aborts - n0)
   endtask
   task automatic t_service();
      busy_reads = 8'h00;
      sw_wr(cpr_pkg::SW_INSN, 32'h0000f000);
      sw_wr(cpr_pkg::SW_INSN, 32'h00005a5a);
      sw_wr(cpr_pkg::SW_CTRL, 32'h00000001);
      repeat (12) @(posedge clk);
      sw_rd(cpr_pkg::SW_STAT, st);
      `CHK("svc", 2'b11, {st[3], st[0]})
      sw_rd(cpr_pkg::SW_RESP, d);
      `CHK("sresp", 16'h8c00, d[15:0])
      sw_wr(cpr_pkg::SW_CTRL, 32'h00000002);
      repeat (10) @(posedge clk);
      sw_rd(cpr_pkg::SW_STAT, st);
      `CHK("sfin", 3'b010, {st[3], st[1:0]})
      sw_rd(cpr_pkg::SW_RESP, d);
      `CHK("sidle", 16'h0802, d[15:0])
   endtask
   task automatic t_refuse();
      logic [15:0] ops [4] = '{16'hf200, 16'he000, 16'hf1c0, 16'hf000};
      for (int i = 0; i < 9; i++) sw_wr(cpr_pkg::SW_INSN, 32'h0000e000);
      sw_rd(cpr_pkg::SW_INSN, d);
      `CHK("words", 4'h8, d[3:0])
      n0 = u_dev.strobes + u_dev.sel_err;
      sw_wr(cpr_pkg::SW_CTRL, 32'h00000001);
      repeat (4) @(posedge clk);
      sw_rd(cpr_pkg::SW_STAT, st);
      `CHK("fmt0", 2'b10, {st[4], st[0]})
      for (int i = 0; i < 4; i++) begin
         run(ops[i], 16'h0001, (i == 3) ? 1 : 2, 1'b0);
         `CHK("fmt", 1'b1, st[4])
      end
      `CHK("nolink", 0, u_dev.strobes + u_dev.sel_err - n0)
   endtask
   task automatic close_out();
      $display("Checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // =====
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Whole run needs well under two thousand cycles
   initial begin
      repeat (6000) @(posedge clk);
      fails++;
      close_out();
   end
   initial begin
      rstn = 1'b0;
      addr = 5'h00;
      wdata = 32'h00000000;
      wr = 1'b0;
      rd = 1'b0;
      busy_reads = 8'h00;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_general();
      t_cond(1'b1, 1'b1);
      t_cond(1'b1, 1'b0);
      t_cond(1'b0, 1'b1);
      t_save();
      t_timeout();
      t_service();
      t_refuse();
      close_out();
   end
endmodule // cpr_host_ctrl_tb
